// [logic/dms_pkg.sv]
// Constants and types for the development-mode start-up handshake
package dms_pkg;

    // ==========================================================
    // Clock and timing
    localparam int unsigned DMS_CLK_MHZ = 100;
    localparam int unsigned DMS_SETUP_TIME_US = 1000;
    localparam int unsigned DMS_SETUP_CYCLES = DMS_SETUP_TIME_US * DMS_CLK_MHZ;

    // ==========================================================
    // Secondary two-wire interface and register map
    localparam logic [7:0] DMS_SEC_ADDR = 8'h34;
    localparam logic [7:0] DMS_REG_IF_STARTUP_CTRL = 8'h06;
    localparam int unsigned DMS_BIT_USE_DEV_PINS = 15;
    localparam int unsigned DMS_BIT_DEV_ADDR = 13;
    localparam int unsigned DMS_BIT_CONFIG_DONE = 12;
    localparam int unsigned DMS_BIT_RELOAD = 11;
    localparam logic DMS_RST_USE_DEV_PINS = 1'h1;
    localparam logic [1:0] DMS_RST_DEV_ADDR = 2'h0;
    localparam logic DMS_RST_CONFIG_DONE = 1'h0;
    localparam logic DMS_RST_RELOAD = 1'h1;
    localparam logic [3:0] DMS_BITS_PER_BYTE = 4'h8;

    // ==========================================================
    // Types
    typedef struct packed {
        logic off;
        logic preactive;
        logic active;
        logic backup;
    } dms_pwr_t;

    typedef struct packed {
        logic use_dev_pins;
        logic [1:0] dev_addr;
        logic config_done;
        logic reload_on_power_on;
    } dms_ctrl_t;

    localparam dms_ctrl_t DMS_CTRL_RESET = '{DMS_RST_USE_DEV_PINS, DMS_RST_DEV_ADDR,
        DMS_RST_CONFIG_DONE, DMS_RST_RELOAD};

    typedef enum logic [8:0] {
        DMS_IDLE = 9'h001,
        DMS_ADDR = 9'h002,
        DMS_ACK_A = 9'h004,
        DMS_PTR = 9'h008,
        DMS_ACK_P = 9'h010,
        DMS_WDATA = 9'h020,
        DMS_ACK_W = 9'h040,
        DMS_RDATA = 9'h080,
        DMS_RACK = 9'h100
    } dms_bus_t;

    typedef struct packed {
        logic scl_m;
        logic scl_s;
        logic scl_d;
        logic sda_m;
        logic sda_s;
        logic sda_d;
        logic cfg_hi_m;
        logic cfg_hi_s;
        logic cfg_lo_m;
        logic cfg_lo_s;
        dms_bus_t bus;
        logic [3:0] bit_cnt;
        logic [7:0] shift;
        logic [7:0] ptr;
        logic byte_idx;
        logic [7:0] data_hi;
        logic [15:0] rd;
        logic sda_oe;
        dms_ctrl_t ctrl;
        logic config_request_out;
        logic first_done;
        logic armed;
        logic [31:0] timer;
        logic abort;
        logic regs_reset;
        logic restart;
        dms_pwr_t pwr_d;
    } dms_st_t;

endpackage : dms_pkg

// [logic/dms_startup.sv]
// Development-mode start-up handshake with secondary two-wire register port
`timescale 1ns/100ps

module dms_startup import dms_pkg::*; #(
    parameter int unsigned SETUP_CYCLES = dms_pkg::DMS_SETUP_CYCLES
) (
    // Clock and reset
    input wire logic clock,
    input wire logic resetn,
    // Configuration select pins
    input wire logic config_select_high,
    input wire logic config_select_low,
    // Secondary two-wire interface
    input wire logic secondary_clock_pin,
    input wire logic secondary_data_pin_in,
    output logic secondary_data_pin_out,
    output logic secondary_data_pin_oe,
    // Request output on general pin one
    output logic general_pin_one_out,
    output logic general_pin_one_oe,
    // Power-state machine
    input wire dms_pkg::dms_pwr_t pwr_state,
    output logic powerup_release,
    output logic abort_to_off,
    output logic regs_reset,
    output logic supply_slot_bypass,
    // Watchdog
    input wire logic wdog_expired,
    input wire logic wdog_disable,
    output logic system_restart,
    // Control fields towards the rest of the device
    output dms_pkg::dms_ctrl_t ctrl_out
);
    import dms_pkg::*;

    // ==========================================================
    // Reset release
    logic [1:0] rst_sync_reg;
    logic rst_n;

    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) begin
            rst_sync_reg <= 2'h0;
        end else begin
            rst_sync_reg <= {rst_sync_reg[0], 1'h1};
        end
    end
    assign rst_n = rst_sync_reg[1];

    // ==========================================================
    // State
    dms_st_t st_reg;
    dms_st_t st_next;
    logic dev_mode;
    logic enabled;
    logic scl_rise;
    logic scl_fall;
    logic bus_start;
    logic bus_stop;
    logic off_entry;
    logic pre_entry;
    logic backup_entry;
    logic [15:0] reg_view;
    logic [15:0] wr_word;

    assign dev_mode = !st_reg.cfg_hi_s && !st_reg.cfg_lo_s;
    // Secondary port only listens while development mode selects the pins
    assign enabled = dev_mode && st_reg.ctrl.use_dev_pins;
    assign scl_rise = st_reg.scl_s && !st_reg.scl_d;
    assign scl_fall = !st_reg.scl_s && st_reg.scl_d;
    assign bus_start = st_reg.scl_s && st_reg.scl_d && st_reg.sda_d && !st_reg.sda_s;
    assign bus_stop = st_reg.scl_s && st_reg.scl_d && !st_reg.sda_d && st_reg.sda_s;
    assign off_entry = pwr_state.off && !st_reg.pwr_d.off;
    assign pre_entry = pwr_state.preactive && !st_reg.pwr_d.preactive;
    assign backup_entry = pwr_state.backup && !st_reg.pwr_d.backup;
    assign wr_word = {st_reg.data_hi, st_reg.shift};

    always_comb begin
        reg_view = 16'h0000;
        if (st_reg.ptr == DMS_REG_IF_STARTUP_CTRL) begin
            reg_view[DMS_BIT_USE_DEV_PINS] = st_reg.ctrl.use_dev_pins;
            reg_view[DMS_BIT_DEV_ADDR +: 2] = st_reg.ctrl.dev_addr;
            reg_view[DMS_BIT_CONFIG_DONE] = st_reg.ctrl.config_done;
            reg_view[DMS_BIT_RELOAD] = st_reg.ctrl.reload_on_power_on;
        end
    end

    // ==========================================================
    // Next state
    always_comb begin
        st_next = st_reg;
        st_next.abort = 1'h0;
        st_next.regs_reset = 1'h0;
        st_next.scl_m = secondary_clock_pin;
        st_next.scl_s = st_reg.scl_m;
        st_next.scl_d = st_reg.scl_s;
        st_next.sda_m = secondary_data_pin_in;
        st_next.sda_s = st_reg.sda_m;
        st_next.sda_d = st_reg.sda_s;
        st_next.cfg_hi_m = config_select_high;
        st_next.cfg_hi_s = st_reg.cfg_hi_m;
        st_next.cfg_lo_m = config_select_low;
        st_next.cfg_lo_s = st_reg.cfg_lo_m;
        st_next.pwr_d = pwr_state;

        // Two-wire slave, clocked by edges seen on the sampled pin
        if (!enabled) begin
            st_next.bus = DMS_IDLE;
            st_next.sda_oe = 1'h0;
        end else if (bus_start) begin
            st_next.bus = DMS_ADDR;
            st_next.bit_cnt = 4'h0;
            st_next.sda_oe = 1'h0;
        end else if (bus_stop) begin
            st_next.bus = DMS_IDLE;
            st_next.sda_oe = 1'h0;
        end else if (scl_rise) begin
            unique case (st_reg.bus)
                DMS_ADDR, DMS_PTR, DMS_WDATA: begin
                    st_next.shift = {st_reg.shift[6:0], st_reg.sda_s};
                    st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                end
                DMS_RACK: begin
                    if (st_reg.sda_s) begin
                        st_next.bus = DMS_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end else if (scl_fall) begin
            unique case (st_reg.bus)
                DMS_ADDR: begin
                    if (st_reg.bit_cnt == DMS_BITS_PER_BYTE) begin
                        if (st_reg.shift[7:1] == DMS_SEC_ADDR[7:1]) begin
                            st_next.sda_oe = 1'h1;
                            st_next.bus = st_reg.shift[0] ? DMS_RACK : DMS_ACK_A;
                            st_next.rd = reg_view;
                        end else begin
                            st_next.bus = DMS_IDLE;
                        end
                    end
                end
                DMS_ACK_A, DMS_ACK_P, DMS_ACK_W: begin
                    st_next.sda_oe = 1'h0;
                    st_next.bit_cnt = 4'h0;
                    st_next.bus = (st_reg.bus == DMS_ACK_A) ? DMS_PTR : DMS_WDATA;
                end
                DMS_PTR: begin
                    if (st_reg.bit_cnt == DMS_BITS_PER_BYTE) begin
                        st_next.ptr = st_reg.shift;
                        st_next.byte_idx = 1'h0;
                        st_next.sda_oe = 1'h1;
                        st_next.bus = DMS_ACK_P;
                    end
                end
                DMS_WDATA: begin
                    if (st_reg.bit_cnt == DMS_BITS_PER_BYTE) begin
                        st_next.sda_oe = 1'h1;
                        st_next.bus = DMS_ACK_W;
                        st_next.byte_idx = !st_reg.byte_idx;
                        if (!st_reg.byte_idx) begin
                            st_next.data_hi = st_reg.shift;
                        end else if (st_reg.ptr == DMS_REG_IF_STARTUP_CTRL) begin
                            st_next.ctrl.use_dev_pins = wr_word[DMS_BIT_USE_DEV_PINS];
                            st_next.ctrl.dev_addr = wr_word[DMS_BIT_DEV_ADDR +: 2];
                            st_next.ctrl.config_done = wr_word[DMS_BIT_CONFIG_DONE];
                            st_next.ctrl.reload_on_power_on = wr_word[DMS_BIT_RELOAD];
                        end
                    end
                end
                DMS_RDATA: begin
                    if (st_reg.bit_cnt == DMS_BITS_PER_BYTE) begin
                        st_next.sda_oe = 1'h0;
                        st_next.bus = DMS_RACK;
                    end else begin
                        st_next.sda_oe = !st_reg.rd[15];
                        st_next.rd = {st_reg.rd[14:0], 1'h0};
                        st_next.bit_cnt = st_reg.bit_cnt + 4'h1;
                    end
                end
                DMS_RACK: begin
                    // Ack seen, ours after the read address or the master's (a nack already went idle): send next byte
                    st_next.sda_oe = !st_reg.rd[15];
                    st_next.rd = {st_reg.rd[14:0], 1'h0};
                    st_next.bit_cnt = 4'h1;
                    st_next.bus = DMS_RDATA;
                end
                default: begin
                end
            endcase
        end

        // Start-up request and set-up timer
        if (pre_entry && dev_mode && !st_reg.config_request_out
                && (st_reg.ctrl.reload_on_power_on || !st_reg.first_done)) begin
            st_next.config_request_out = 1'h1;
            st_next.armed = 1'h1;
            st_next.timer = 32'h0;
        end else if (st_reg.armed) begin
            if (st_reg.ctrl.config_done || !pwr_state.preactive) begin
                st_next.armed = 1'h0;
            end else if (st_reg.timer == SETUP_CYCLES[31:0] - 32'h1) begin
                st_next.abort = 1'h1;
                st_next.armed = 1'h0;
            end else begin
                st_next.timer = st_reg.timer + 32'h1;
            end
        end
        if (powerup_release) begin
            st_next.first_done = 1'h1;
        end

        // Register reset on OFF entry (reload set) and on BACKUP entry outranks a same-cycle write
        if (off_entry && st_reg.ctrl.reload_on_power_on) begin
            st_next.ctrl = DMS_CTRL_RESET;
            st_next.regs_reset = 1'h1;
            st_next.config_request_out = 1'h0;
            st_next.armed = 1'h0;
        end else if (off_entry) begin
            st_next.armed = 1'h0;
        end
        // Request stays high here, so no new rise arms the timer afterwards
        if (backup_entry) begin
            st_next.ctrl = DMS_CTRL_RESET;
            st_next.regs_reset = 1'h1;
            st_next.armed = 1'h0;
        end

        st_next.restart = wdog_expired && !wdog_disable;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            // Power history starts in OFF so release from reset is no OFF entry
            st_reg <= '{bus: DMS_IDLE, ctrl: DMS_CTRL_RESET, scl_m: 1'h1, scl_s: 1'h1,
                scl_d: 1'h1, sda_m: 1'h1, sda_s: 1'h1, sda_d: 1'h1, cfg_hi_m: 1'h1,
                cfg_hi_s: 1'h1, cfg_lo_m: 1'h1, cfg_lo_s: 1'h1,
                pwr_d: '{off: 1'h1, default: 1'h0}, default: '0};
        end else begin
            st_reg <= st_next;
        end
    end

    // ==========================================================
    // Outputs
    assign secondary_data_pin_out = 1'h0;
    assign secondary_data_pin_oe = st_reg.sda_oe;
    assign general_pin_one_out = st_reg.config_request_out;
    assign general_pin_one_oe = dev_mode;
    // Done only gates start-up in development mode; a reset-triggered
    // configurator sets it early and programs after ACTIVE
    assign powerup_release = pwr_state.preactive
        && (!dev_mode || st_reg.ctrl.config_done);
    assign abort_to_off = st_reg.abort;
    assign regs_reset = st_reg.regs_reset;
    assign supply_slot_bypass = pwr_state.active;
    assign system_restart = st_reg.restart;
    assign ctrl_out = st_reg.ctrl;

endmodule : dms_startup

// [testbench/dms_startup_monitor.sv]
// Port checker for the start-up handshake
`timescale 1ns/100ps
module dms_startup_monitor #(
    parameter int unsigned SETUP_CYCLES = 100
) (
    // Clock and reset
    input logic clock,
    input logic resetn,
    // Watched ports
    input logic general_pin_one_out,
    input logic general_pin_one_oe,
    input dms_pkg::dms_pwr_t pwr_state,
    input logic powerup_release,
    input logic abort_to_off,
    input logic regs_reset,
    input logic supply_slot_bypass,
    input logic wdog_expired,
    input logic wdog_disable,
    input logic system_restart,
    input dms_pkg::dms_ctrl_t ctrl_out
);
    import dms_pkg::*;
    logic [31:0] pre_cnt_reg;
    // ============================================================
    // Cycles spent in PRE-ACTIVE, for the set-up timeout figure
    always_ff @(posedge clock or negedge resetn) begin
        if (!resetn) pre_cnt_reg <= 32'h0;
        else pre_cnt_reg <= pwr_state.preactive ? pre_cnt_reg + 32'h1 : 32'h0;
    end
    default clocking @(posedge clock); endclocking
    default disable iff (!resetn);
    // ============================================================
    // Steps of a register clear
    sequence s_clear;
        regs_reset ##1 (ctrl_out == DMS_CTRL_RESET);
    endsequence
    sequence s_off_in;
        $rose(pwr_state.off) && ctrl_out.reload_on_power_on;
    endsequence
    hold_release_a: assert property (pwr_state.preactive && general_pin_one_oe
        && !ctrl_out.config_done |-> !powerup_release) else $error("early release");
    give_release_a: assert property (pwr_state.preactive && ctrl_out.config_done
        |-> powerup_release) else $error("release missing");
    slot_bypass_a: assert property (supply_slot_bypass == pwr_state.active)
        else $error("bypass wrong");
    wdog_restart_a: assert property (wdog_expired && !wdog_disable |=> system_restart)
        else $error("no restart");
    wdog_mask_a: assert property (wdog_disable |=> !system_restart)
        else $error("restart not masked");
    setup_timeout_a: assert property (abort_to_off |-> pre_cnt_reg == SETUP_CYCLES + 1
        && !ctrl_out.config_done) else $error("timeout wrong");
    request_rise_a: assert property ($rose(pwr_state.preactive) && general_pin_one_oe
        && !general_pin_one_out && ctrl_out.reload_on_power_on |=> general_pin_one_out)
        else $error("no request");
    off_drop_a: assert property (s_off_in |=> !general_pin_one_out)
        else $error("request kept");
    off_clear_a: assert property (s_off_in |=> s_clear) else $error("no clear at off");
    keep_request_a: assert property (!ctrl_out.reload_on_power_on && general_pin_one_out
        |=> general_pin_one_out) else $error("request dropped");
    backup_clear_a: assert property ($rose(pwr_state.backup) |=> s_clear)
        else $error("no clear at backup");
    backup_keep_a: assert property ($rose(pwr_state.backup) && general_pin_one_out
        |=> general_pin_one_out [*3]) else $error("backup drop");
endmodule : dms_startup_monitor
bind dms_startup dms_startup_monitor #(.SETUP_CYCLES(SETUP_CYCLES)) mon (.*);

// [testbench/dms_genie.sv]
// Configurator model on the secondary two-wire pins
`timescale 1ns/100ps
module dms_genie (
    // Clock
    input logic clock,
    // Two-wire lines, data open drain with pull-up
    input logic sda,
    output logic scl,
    output logic sda_low
);
    // Supplies start from time slots here; a reset-triggered flow spaces enables apart
    initial begin
        scl = 1'h1;
        sda_low = 1'h0;
    end
    // ============================================================
    // Bit timing: 4 clocks low, 4 high, data moved mid-low
    task automatic bit_io(input logic b, output logic r);
        repeat (2) @(posedge clock);
        sda_low <= !b;
        repeat (2) @(posedge clock);
        scl <= 1'h1;
        repeat (4) @(posedge clock);
        r = sda;
        scl <= 1'h0;
    endtask : bit_io
    task automatic byte_io(input logic [7:0] b, input logic mack, output logic [7:0] r,
        output logic ack);
        logic a;
        for (int i = 7; i >= 0; i--) begin
            bit_io(b[i], r[i]);
        end
        bit_io(!mack, a);
        ack = !a;
    endtask : byte_io
    task automatic wr(input logic [7:0] dev, input logic [7:0] ptr, input logic [15:0] val,
        input int n, output logic ok);
        logic [7:0] r;
        logic a;
        @(posedge clock);
        sda_low <= 1'h1;
        repeat (4) @(posedge clock);
        scl <= 1'h0;
        byte_io(dev, 1'h0, r, ok);
        byte_io(ptr, 1'h0, r, a);
        ok = ok & a; // A missing acknowledge marks the transfer as failed
        for (int k = 0; k < n; k++) begin
            byte_io(k ? val[7:0] : val[15:8], 1'h0, r, a);
            ok = ok & a;
        end
        stop_bit();
    endtask : wr
    task automatic rd(output logic [15:0] v);
        logic a;
        @(posedge clock);
        sda_low <= 1'h1;
        repeat (4) @(posedge clock);
        scl <= 1'h0;
        byte_io(8'h35, 1'h0, v[15:8], a);
        byte_io(8'hff, 1'h1, v[15:8], a);
        byte_io(8'hff, 1'h0, v[7:0], a);
        stop_bit();
    endtask : rd
    // Stop: data rises while the clock is high, then both lines idle high
    task automatic stop_bit();
        repeat (2) @(posedge clock);
        sda_low <= 1'h1;
        repeat (2) @(posedge clock);
        scl <= 1'h1;
        repeat (4) @(posedge clock);
        sda_low <= 1'h0;
        repeat (4) @(posedge clock);
    endtask : stop_bit
endmodule : dms_genie

// [testbench/dms_startup_tb.sv]
// Self-checking bench for the start-up handshake
`timescale 1ns/100ps
module dms_startup_tb;
    import dms_pkg::*;
    localparam int unsigned SC = 1000;
    localparam dms_pwr_t OFF = 4'h8, PRE = 4'h4, ACT = 4'h2, BAK = 4'h1;
    logic clock, resetn = 1'h0, sel_hi = 1'h0, sel_lo = 1'h0, wexp = 1'h0, wdis = 1'h0;
    logic scl, sda_low, sda, sda_oe, sda_out, pin_out, pin_oe, rel, abrt, rst_out, ok;
    logic [15:0] v;
    dms_pwr_t pwr = OFF;
    dms_ctrl_t ctrl;
    int n_fail = 0, checked = 0, n;
    assign sda = !(sda_low || (sda_oe && !sda_out));
    dms_startup #(.SETUP_CYCLES(SC)) dut (.clock(clock), .resetn(resetn),
        .config_select_high(sel_hi), .config_select_low(sel_lo), .secondary_clock_pin(scl),
        .secondary_data_pin_in(sda), .secondary_data_pin_out(sda_out),
        .secondary_data_pin_oe(sda_oe),
        .general_pin_one_out(pin_out), .general_pin_one_oe(pin_oe), .pwr_state(pwr),
        .powerup_release(rel), .abort_to_off(abrt), .regs_reset(), .supply_slot_bypass(),
        .wdog_expired(wexp), .wdog_disable(wdis), .system_restart(rst_out), .ctrl_out(ctrl));
    dms_genie cfg (.clock(clock), .sda(sda), .scl(scl), .sda_low(sda_low));
    initial begin
        clock = 1'h0;
        forever #5 clock = ~clock;
    end
    // Bounded run: the whole sequence needs about 3400 cycles
    initial begin
        #500000;
        n_fail++;
        test_done();
    end
    // ============================================================
    // Helpers
    task automatic step(input int k);
        repeat (k) @(posedge clock);
        #1;
    endtask : step
    task automatic setp(input dms_pwr_t p);
        @(posedge clock);
        pwr <= p;
    endtask : setp
    task automatic chk(input string nm, input logic [15:0] exp, input logic [15:0] got);
        checked++;
        if (got !== exp) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, exp, got);
        end
    endtask : chk
    // ============================================================
    // Scenarios
    task automatic t_reg();
        cfg.wr(8'h36, 8'h06, 16'h0, 0, ok);
        chk("foreign address ack", 16'h0, ok);
        cfg.wr(8'h34, 8'h06, 16'h0, 0, ok);
        chk("own address ack", 16'h1, ok);
        cfg.rd(v);
        chk("control reset value", 16'h8800, v);
        chk("pin one enable", 16'h1, pin_oe);
        $display("t_reg done");
    endtask : t_reg
    task automatic t_first();
        setp(PRE);
        step(1);
        chk("request raised", 16'h1, pin_out);
        cfg.wr(8'h34, 8'h06, 16'h9800, 2, ok);
        chk("done written", 16'h13, ctrl);
        chk("release given", 16'h1, rel);
        setp(ACT);
        setp(OFF);
        step(3);
        chk("request dropped", 16'h0, pin_out);
        chk("control cleared", 16'h11, ctrl);
        $display("t_first done");
    endtask : t_first
    task automatic t_abort();
        n = 0;
        setp(PRE);
        while (n < SC + 20 && abrt !== 1'h1) begin
            step(1);
            n++;
        end
        chk("set-up timeout", SC + 1, n);
        setp(OFF);
        $display("t_abort done");
    endtask : t_abort
    task automatic t_keep();
        setp(PRE);
        cfg.wr(8'h34, 8'h06, 16'h9000, 2, ok);
        setp(ACT);
        setp(OFF);
        step(3);
        chk("request kept", 16'h1, pin_out);
        chk("control kept", 16'h12, ctrl);
        setp(PRE);
        step(2);
        chk("release at once", 16'h1, rel);
        $display("t_keep done");
    endtask : t_keep
    task automatic t_backup();
        ok = 1'h0;
        setp(BAK);
        step(3);
        chk("request in backup", 16'h1, pin_out);
        chk("backup clears", 16'h11, ctrl);
        setp(PRE);
        repeat (SC + 10) begin
            step(1);
            ok = ok | abrt;
        end
        chk("no fallback", 16'h0, ok);
        chk("still waiting", 16'h0, rel);
        $display("t_backup done");
    endtask : t_backup
    task automatic t_wdog();
        @(posedge clock);
        wexp <= 1'h1;
        step(1);
        chk("restart", 16'h1, rst_out);
        @(posedge clock);
        wdis <= 1'h1;
        step(1);
        chk("restart masked", 16'h0, rst_out);
        @(posedge clock);
        wexp <= 1'h0;
        wdis <= 1'h0;
        $display("t_wdog done");
    endtask : t_wdog
    task automatic t_mode();
        @(posedge clock);
        sel_lo <= 1'h1;
        step(4);
        chk("pin one released", 16'h0, pin_oe);
        chk("release without done", 16'h1, rel);
        cfg.wr(8'h34, 8'h06, 16'h0, 0, ok);
        chk("port off outside dev mode", 16'h0, ok);
        @(posedge clock);
        sel_lo <= 1'h0;
        $display("t_mode done");
    endtask : t_mode
    task automatic test_done();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : test_done
    initial begin
        repeat (16) @(posedge clock);
        resetn <= 1'h1;
        step(8);
        t_reg();
        t_first();
        t_abort();
        t_keep();
        t_backup();
        t_wdog();
        t_mode();
        test_done();
    end
endmodule : dms_startup_tb
